// *** design/led_enc_pkg.sv ***
// Constants and types shared by the converter status lamp encoder
package led_enc_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATE_OFFSET = 8'h04;
   localparam logic [7:0] LAMP_OFFSET = 8'h08;
   localparam logic [7:0] MODE_OFFSET = 8'h0c;

   // ----------------------------------------
   // Field layouts and reset values
   // ----------------------------------------
   localparam int GROUP_SEL_W = 3;
   localparam logic [2:0] GROUP_SEL_RESET = 3'h0;
   localparam int STATE_W = 13;
   localparam logic [12:0] STATE_RESET = 13'h0000;
   localparam int ST_FAULT = 0;
   localparam int ST_OVERLOAD = 1;
   localparam int ST_SAFE_STOP = 2;
   localparam int ST_REDUCED_SPEED = 3;
   localparam int ST_READY = 4;
   localparam int ST_QUICK_COMM = 5;
   localparam int ST_TEST_DUE = 6;
   localparam int ST_NO_COMM = 7;
   localparam int ST_PARAM_XFER = 8;
   localparam int ST_FW_UPDATE = 9;
   localparam int ST_SAFETY_COMM = 10;
   localparam int ST_PULSE_ENABLE = 11;
   localparam int ST_INTERMEDIATE_CIRCUIT_LAMP = 12;
   localparam int LAMP_W = 12;
   localparam logic [11:0] LAMP_RESET = 12'h000;
   localparam int LP_FAULT = 0;
   localparam int LP_READY = 1;
   localparam int LP_SAFE_STOP = 2;
   localparam int LP_OVERLOAD = 3;
   localparam int LP_GROUP = 4;
   localparam int LP_OUTPUT = 10;
   localparam int LP_INTERMEDIATE_CIRCUIT_LAMP = 11;
   localparam int GROUPS = 6;
   localparam logic [2:0] GROUP_SEL_MAX = 3'h5;

   // ----------------------------------------
   // Flash timing
   // ----------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int FAST_HALF_MS = 250;
   localparam int SLOW_HALF_MS = 1000;
   localparam int FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
   localparam int SLOW_RATIO = SLOW_HALF_MS / FAST_HALF_MS;
   localparam logic [1:0] SLOW_DIV_LAST = 2'(SLOW_RATIO - 1);
   localparam int CNT_W = 23;
   typedef logic [CNT_W-1:0] cnt_t;
   localparam cnt_t CNT_RESET = 23'h000000;

   // ----------------------------------------
   // Display override modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      DISP_NORMAL,
      DISP_FW_UPDATE,
      DISP_PARAM_XFER,
      DISP_SAFETY_COMM
   } disp_t;

endpackage : led_enc_pkg

// *** design/flash_if.sv ***
// Flash phase signals passed from the divider to the encoder
`timescale 1ns/1ns
interface flash_if;
   logic fast;
   logic slow;
   modport gen (output fast, output slow);
   modport sink (input fast, input slow);
endinterface : flash_if

// *** design/flash_divider.sv ***
// Clock divider producing the 2 Hz and 0.5 Hz flash phases
`timescale 1ns/1ns
module flash_divider #(
   parameter int unsigned HALF_CYC = led_enc_pkg::FAST_HALF_CYC
) (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Flash phases
   flash_if.gen flash
);

   typedef struct packed {
      led_enc_pkg::cnt_t cnt;
      logic [1:0] div;
      logic fast;
      logic slow;
   } div_t;

   div_t s_q;
   div_t s_d;

   // Both phases start low together so all flashing stays in step
   always_comb begin
      s_d = s_q;
      if (s_q.cnt == led_enc_pkg::cnt_t'(HALF_CYC - 1)) begin
         s_d.cnt = led_enc_pkg::CNT_RESET;
         s_d.fast = ~s_q.fast;
         s_d.div = s_q.div + 2'h1;
         if (s_q.div == led_enc_pkg::SLOW_DIV_LAST) begin
            s_d.slow = ~s_q.slow;
            s_d.div = 2'h0;
         end
      end else begin
         s_d.cnt = s_q.cnt + led_enc_pkg::cnt_t'(1);
      end
   end

   // State register, frozen while ce is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign flash.fast = s_q.fast;
   assign flash.slow = s_q.slow;

endmodule : flash_divider

// *** design/converter_status_led_encoder.sv ***
// Front-panel and power-module lamp encoder with AHB-Lite register access
// Register map, one aligned word each, unmapped words read zero and ignore writes
//    0x00 control: bits 2:0 select the shutdown group, read and write
//    0x04 state: bits 12:0 force converter states in software, ORed with the inputs
//    0x08 lamps: bits 11:0 show the registered lamp word, read only
//    0x0c mode: bits 1:0 display mode, bit 4 fast phase, bit 5 slow phase, bits 20:8 effective state
//
// Lamp word layout
//    bit 0 fault, bit 1 ready, bit 2 safe stop, bit 3 overload
//    bits 9:4 shutdown groups one to six, bit 10 output, bit 11 intermediate circuit
//
// Display priority
//    Firmware update lights all ten panel lamps
//    Parameter transfer darkens all ten panel lamps
//    Safety commissioning replaces only the group lamps by the 2 Hz flash
//    Otherwise the normal pattern: test due, fault, reduced speed, safe stop,
//    quick commissioning, missing link, overload, ready
//    The two power-module lamps follow their states in every mode
//
// Timing
//    One wait state per bus transfer, so a single transfer takes two cycles
//    Lamps follow the converter states one clock later
//    Both flash phases start low together after reset and stay aligned
//    Reset darkens every lamp and leaves the bus ready
//    Clock enable low freezes the bus slave too
//
// Hazards
//    A forced state stays until software writes it back to zero
//    Group select values 0, 6 and 7 light group six alone when the link is missing
//    Test due outranks a present fault, so a fault during the test wait only flashes
//    Reduced speed outranks a plain safe stop, because both share the safe-stop lamp
//    The ready flash uses the fast phase; no other rate is offered for it
//    Size is not checked: every access is treated as a whole word
//    A transfer offered while ce is low with the bus idle is lost: hreadyout stays high, so the master completes it unseen
//
`timescale 1ns/1ns
module converter_status_led_encoder #(
   parameter int unsigned FLASH_HALF_CYC = led_enc_pkg::FAST_HALF_CYC
) (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Converter states from on-chip logic
   input wire logic [12:0] state_in,
   // Control-unit lamps
   output logic fault_lamp,
   output logic ready_lamp,
   output logic safe_stop_lamp,
   output logic overload_lamp,
   output logic [5:0] shutdown_group_lamps,
   // Power-module lamps
   output logic output_lamp,
   output logic intermediate_circuit_lamp
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   // All state of the module in one packed struct
   // Bus fields: pend marks a data phase in progress, wr and addr hold its address phase
   // ready_out and rdata are the registered answers seen on the bus
   // group_sel and sw_state are the two writable registers
   // mode and lamps register the display so every lamp comes from a flip-flop
   typedef struct packed {
      logic pend;
      logic wr;
      logic [7:0] addr;
      logic ready_out;
      logic [31:0] rdata;
      logic [2:0] group_sel;
      logic [12:0] sw_state;
      led_enc_pkg::disp_t mode;
      logic [11:0] lamps;
   } regs_t;

   regs_t s_q;
   regs_t s_d;

   // Flash phases from the divider
   flash_if flash ();

   // Combinational next values of the display
   logic [12:0] eff;
   logic [11:0] lamps_n;
   logic [5:0] group_n;
   led_enc_pkg::disp_t mode_n;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Word decode: upper address bits must be zero, low two bits ignored
   // Upper bits outside the map force a miss, so aliases never appear
   function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
      hit = (a[31:8] == 24'h000000) && (a[7:2] == off[7:2]);
   endfunction : hit

   // One-hot lamp for a shutdown group number 1 to 5, none otherwise
   // Group six is added by the caller
   function automatic logic [5:0] group_onehot(input logic [2:0] sel);
      logic [5:0] v;
      v = 6'h00;
      if (sel != 3'h0 && sel <= led_enc_pkg::GROUP_SEL_MAX) begin
         v[sel - 3'h1] = 1'b1;
      end
      group_onehot = v;
   endfunction : group_onehot

   // Read mux over the register map, unmapped words read zero
   // Mode word also shows both flash phases and the effective state
   // Reads have no side effects
   function automatic logic [31:0] read_word(input logic [31:0] a, input regs_t r);
      logic [31:0] v;
      v = 32'h00000000;
      if (hit(a, led_enc_pkg::CTRL_OFFSET)) begin
         v[2:0] = r.group_sel;
      end else if (hit(a, led_enc_pkg::STATE_OFFSET)) begin
         v[12:0] = r.sw_state;
      end else if (hit(a, led_enc_pkg::LAMP_OFFSET)) begin
         v[11:0] = r.lamps;
      end else if (hit(a, led_enc_pkg::MODE_OFFSET)) begin
         v[1:0] = r.mode;
         v[4] = flash.fast;
         v[5] = flash.slow;
         v[20:8] = eff;
      end
      read_word = v;
   endfunction : read_word

   // ----------------------------------------
   // Flash generator
   // ----------------------------------------

   // Divided system clock supplies both flash rates
   // Fast phase drives the 2 Hz lamps, slow phase the 0.5 Hz fault flash
   flash_divider #(
      .HALF_CYC(FLASH_HALF_CYC)
   ) u_flash (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .flash(flash)
   );

   // ----------------------------------------
   // Effective converter state
   // ----------------------------------------

   // Hardware states and software-forced states combine
   // A forced state cannot be cleared by hardware
   assign eff = state_in | s_q.sw_state;

   // Override mode: update beats transfer beats safety commissioning
   // Only one override shows at a time
   always_comb begin
      if (eff[led_enc_pkg::ST_FW_UPDATE]) begin
         mode_n = led_enc_pkg::DISP_FW_UPDATE;
      end else if (eff[led_enc_pkg::ST_PARAM_XFER]) begin
         mode_n = led_enc_pkg::DISP_PARAM_XFER;
      end else if (eff[led_enc_pkg::ST_SAFETY_COMM]) begin
         mode_n = led_enc_pkg::DISP_SAFETY_COMM;
      end else begin
         mode_n = led_enc_pkg::DISP_NORMAL;
      end
   end

   // ----------------------------------------
   // Lamp encoding
   // ----------------------------------------

   // Lamp word bits follow the layout in the file header
   // Group lamps in normal display
   // Group select outside 1 to 5 leaves group six alone lit
   always_comb begin
      group_n = 6'h00;
      if (eff[led_enc_pkg::ST_NO_COMM] && !eff[led_enc_pkg::ST_FAULT]) begin
         group_n = group_onehot(s_q.group_sel);
         group_n[led_enc_pkg::GROUPS-1] = 1'b1;
      end
   end

   // Panel pattern, one row of the state table at a time
   // Earlier rows win on lamp bits 3:0; the group lamps light for a missing link whenever no fault is present
   always_comb begin
      lamps_n = led_enc_pkg::LAMP_RESET;
      if (eff[led_enc_pkg::ST_TEST_DUE]) begin
         lamps_n[led_enc_pkg::LP_FAULT] = flash.slow;
      end else if (eff[led_enc_pkg::ST_FAULT]) begin
         lamps_n[led_enc_pkg::LP_FAULT] = 1'b1;
         if (eff[led_enc_pkg::ST_SAFE_STOP]) begin
            lamps_n[led_enc_pkg::LP_SAFE_STOP] = 1'b1;
         end else if (eff[led_enc_pkg::ST_OVERLOAD]) begin
            lamps_n[led_enc_pkg::LP_OVERLOAD] = 1'b1;
         end
      end else if (eff[led_enc_pkg::ST_REDUCED_SPEED]) begin
         lamps_n[led_enc_pkg::LP_SAFE_STOP] = 1'b1;
         lamps_n[led_enc_pkg::LP_OVERLOAD] = 1'b1;
      end else if (eff[led_enc_pkg::ST_SAFE_STOP]) begin
         lamps_n[led_enc_pkg::LP_SAFE_STOP] = 1'b1;
      end else if (eff[led_enc_pkg::ST_QUICK_COMM]) begin
         lamps_n[led_enc_pkg::LP_READY] = flash.fast;
      end else if (eff[led_enc_pkg::ST_NO_COMM]) begin
         lamps_n[led_enc_pkg::LP_READY] = flash.fast;
      end else if (eff[led_enc_pkg::ST_OVERLOAD]) begin
         lamps_n[led_enc_pkg::LP_OVERLOAD] = 1'b1;
      end else if (eff[led_enc_pkg::ST_READY]) begin
         lamps_n[led_enc_pkg::LP_READY] = 1'b1;
      end
      lamps_n[led_enc_pkg::LP_GROUP +: 6] = group_n;

      // Overrides replace the panel pattern
      case (mode_n)
         led_enc_pkg::DISP_FW_UPDATE: begin
            lamps_n[9:0] = 10'h3ff;
         end
         led_enc_pkg::DISP_PARAM_XFER: begin
            lamps_n[9:0] = 10'h000;
         end
         led_enc_pkg::DISP_SAFETY_COMM: begin
            lamps_n[led_enc_pkg::LP_GROUP +: 6] = {6{flash.fast}};
         end
         default: begin
         end
      endcase

      // Power-module lamps follow their own states in every mode
      lamps_n[led_enc_pkg::LP_OUTPUT] = eff[led_enc_pkg::ST_PULSE_ENABLE];
      lamps_n[led_enc_pkg::LP_INTERMEDIATE_CIRCUIT_LAMP] = eff[led_enc_pkg::ST_INTERMEDIATE_CIRCUIT_LAMP];
   end

   // ----------------------------------------
   // Bus slave and next state
   // ----------------------------------------

   // One wait state per transfer so read data leaves a flip-flop
   // Cycle 1: address phase seen, answer held low
   // Cycle 2: write lands or read word is fetched, answer raised
   // The next address phase may follow at once
   // Writes outside the two writable words are dropped
   always_comb begin
      s_d = s_q;
      s_d.mode = mode_n;
      s_d.lamps = lamps_n;
      if (s_q.pend) begin
         // Data phase: write or fetch, then release the bus
         s_d.pend = 1'b0;
         s_d.ready_out = 1'b1;
         s_d.rdata = 32'h00000000;
         if (s_q.wr) begin
            if (hit({24'h000000, s_q.addr}, led_enc_pkg::CTRL_OFFSET)) begin
               s_d.group_sel = hwdata[2:0];
            end
            if (hit({24'h000000, s_q.addr}, led_enc_pkg::STATE_OFFSET)) begin
               s_d.sw_state = hwdata[12:0];
            end
         end else begin
            s_d.rdata = read_word({24'h000000, s_q.addr}, s_q);
         end
      end else if (hsel && htrans[1] && hready) begin
         // Address phase accepted
         s_d.pend = 1'b1;
         s_d.ready_out = 1'b0;
         s_d.wr = hwrite;
         // Address beyond the map becomes an offset that never hits
         s_d.addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
      end
   end

   // State register, frozen while ce is low
   // Ready high in reset so the first transfer may start at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.pend <= 1'b0;
         s_q.wr <= 1'b0;
         s_q.addr <= 8'h00;
         s_q.ready_out <= 1'b1;
         s_q.rdata <= 32'h00000000;
         s_q.group_sel <= led_enc_pkg::GROUP_SEL_RESET;
         s_q.sw_state <= led_enc_pkg::STATE_RESET;
         s_q.mode <= led_enc_pkg::DISP_NORMAL;
         s_q.lamps <= led_enc_pkg::LAMP_RESET;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------

   // Bus answers
   assign hreadyout = s_q.ready_out;
   assign hrdata = s_q.rdata;
   assign hresp = 1'b0; // Always OKAY

   // Lamps straight from the lamp register
   assign fault_lamp = s_q.lamps[led_enc_pkg::LP_FAULT];
   assign ready_lamp = s_q.lamps[led_enc_pkg::LP_READY];
   assign safe_stop_lamp = s_q.lamps[led_enc_pkg::LP_SAFE_STOP];
   assign overload_lamp = s_q.lamps[led_enc_pkg::LP_OVERLOAD];
   assign shutdown_group_lamps = s_q.lamps[led_enc_pkg::LP_GROUP +: 6];

   // Power-module lamps
   assign output_lamp = s_q.lamps[led_enc_pkg::LP_OUTPUT];
   assign intermediate_circuit_lamp = s_q.lamps[led_enc_pkg::LP_INTERMEDIATE_CIRCUIT_LAMP];

   // hsize is accepted but not checked: only whole words are used
   logic unused_size;
   assign unused_size = ^hsize;

endmodule : converter_status_led_encoder

// *** verif/status_lamp_sva.sv ***
// Port checker for the converter status lamp encoder
`timescale 1ns/1ns
module status_lamp_sva #(
   parameter int unsigned FLASH_HALF_CYC = 4
) (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // States and lamps
   input wire logic [12:0] state_in,
   input wire logic fault_lamp,
   input wire logic ready_lamp,
   input wire logic safe_stop_lamp,
   input wire logic overload_lamp,
   input wire logic [5:0] shutdown_group_lamps,
   input wire logic output_lamp,
   input wire logic intermediate_circuit_lamp
);
   // ----------------------------------------
   // Helper terms
   // ----------------------------------------
   // Four panel lamps and mode qualifiers
   wire [3:0] p = {overload_lamp, safe_stop_lamp, ready_lamp, fault_lamp};
   wire [5:0] g = shutdown_group_lamps;
   wire nrm = !state_in[6] && !state_in[8] && !state_in[9];
   wire sc = state_in[10] && !state_in[8] && !state_in[9];
   logic [7:0] run_q;
   // Cycles the group lamps stayed unchanged while safety commissioning
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) run_q <= 8'h00;
      else if (!sc || !ce || g != $past(g)) run_q <= 8'h00;
      else run_q <= run_q + 8'h01;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_update_all_lit: assert property (ce && state_in[9] |=> {g, p} == 10'h3ff)
      else $error("panel not all lit in update");
   a_xfer_all_dark: assert property (ce && state_in[8] && !state_in[9] |=> {g, p} == 10'h000)
      else $error("panel not dark in transfer");
   a_fault_safe: assert property (ce && nrm && state_in[0] && state_in[2] |=> p == 4'b0101)
      else $error("fault with safe stop pattern wrong");
   a_fault_ovl: assert property (ce && nrm && state_in[0] && state_in[1] && !state_in[2] |=> p == 4'b1001)
      else $error("overload shutdown pattern wrong");
   a_safe_only: assert property (ce && nrm && !state_in[0] && !state_in[3] && state_in[2] |=> p == 4'b0100)
      else $error("safe stop pattern wrong");
   a_reduced_speed: assert property (ce && nrm && !state_in[0] && state_in[3] |=> p == 4'b1100)
      else $error("reduced speed pattern wrong");
   a_group_six: assert property (ce && !sc && state_in[7] && !state_in[0] && !state_in[8] && !state_in[9]
      |=> g[5] && $countones(g) <= 2)
      else $error("group lamps wrong without link");
   a_power_lamps: assert property (ce |=> output_lamp == $past(state_in[11])
      && intermediate_circuit_lamp == $past(state_in[12]))
      else $error("power module lamps wrong");
   a_group_phase: assert property (ce && sc |=> g == 6'h00 || g == 6'h3f)
      else $error("group lamps out of phase");
   a_flash_half: assert property (run_q <= 8'(FLASH_HALF_CYC))
      else $error("group flash half period too long");
   a_bus_wait: assert property (ce && hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   // Main scenarios reached
   c_update: cover property (ce && state_in[9]);
   c_safety: cover property (ce && sc && run_q == 8'(FLASH_HALF_CYC - 1));
   c_bus: cover property (hsel && htrans[1] && hready);
endmodule : status_lamp_sva

bind converter_status_led_encoder status_lamp_sva #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) status_lamp_sva_inst (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .state_in(state_in), .fault_lamp(fault_lamp),
   .ready_lamp(ready_lamp), .safe_stop_lamp(safe_stop_lamp), .overload_lamp(overload_lamp),
   .shutdown_group_lamps(shutdown_group_lamps), .output_lamp(output_lamp),
   .intermediate_circuit_lamp(intermediate_circuit_lamp));

// *** verif/lamp_viewer.sv ***
// Operator view of the lamps: length of the last lit phase of each lamp
`timescale 1ns/1ns
module lamp_viewer (
   // Clock, reset, clear
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   // Lamps as seen
   input wire logic [11:0] lamps,
   // Last lit length per lamp
   output logic [7:0] lit_len [12]
);
   logic [7:0] run_q [12];
   // Count lit cycles and keep the count when a lamp goes dark
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 12; i++) begin
            run_q[i] <= 8'h00;
            lit_len[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 12; i++) begin
            run_q[i] <= lamps[i] ? run_q[i] + 8'h01 : 8'h00;
            if (clr) lit_len[i] <= 8'h00;
            else if (!lamps[i] && run_q[i] != 8'h00) lit_len[i] <= run_q[i];
         end
      end
   end
endmodule : lamp_viewer

// *** verif/testbench.sv ***
// Self-checking bench for the converter status lamp encoder
`timescale 1ns/1ns
module testbench;
   localparam int unsigned HALF = 4;
   logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [12:0] state_in = 13'h0000;
   logic hreadyout, hresp, fl, rl, sl, ol, outl, dcl;
   logic [5:0] grp;
   logic [7:0] lit_len [12];
   logic [15:0] rnd = 16'hf6b0;
   int errors = 0, cmp_count = 0;
   wire [11:0] lamps = {dcl, outl, grp, ol, sl, rl, fl};
   // Clock of 50 ns
   always #25 hclk = ~hclk;
   // Design and lamp viewer
   converter_status_led_encoder #(.FLASH_HALF_CYC(HALF)) converter_status_led_encoder_inst (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .state_in(state_in), .fault_lamp(fl), .ready_lamp(rl),
      .safe_stop_lamp(sl), .overload_lamp(ol), .shutdown_group_lamps(grp), .output_lamp(outl),
      .intermediate_circuit_lamp(dcl));
   lamp_viewer lamp_viewer_inst (.hclk(hclk), .hresetn(hresetn), .clr(clr), .lamps(lamps), .lit_len(lit_len));
   // ----------------------------------------
   // Expectations and helpers
   // ----------------------------------------
   // Pseudo-random source
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   // Steady lamp word for states without flashing
   function automatic logic [11:0] exp_lamps(input logic [12:0] s);
      logic [11:0] l;
      l = {s[12], s[11], 10'h000};
      if (s[9]) l[9:0] = 10'h3ff;
      else if (!s[8]) begin
         l[0] = s[0];
         l[1] = !s[0] && !s[1] && !s[2] && !s[3] && s[4];
         l[2] = s[2] || (!s[0] && s[3]);
         l[3] = s[0] ? (s[1] && !s[2]) : (s[3] || (s[1] && !s[2]));
      end
      return l;
   endfunction : exp_lamps
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask : tick
   task automatic put(input logic [12:0] s);
      @(posedge hclk);
      state_in <= s;
      tick(2);
   endtask : put
   // One single transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge hclk);
            n++;
         end while (hreadyout !== 1'b1 && n < 50);
         if (n >= 50) begin
            errors++;
            complete_run();
         end
         if (p == 0) begin
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
         end
      end
      rd = hrdata;
   endtask : bus
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [12:0] s;
      logic [12:0] cor [4] = '{13'h0700, 13'h0580, 13'h0005, 13'h000c};
      logic [12:0] fst [4] = '{13'h0040, 13'h0020, 13'h0400, 13'h0080};
      int fidx [4] = '{0, 1, 4, 1};
      logic [12:0] mst [4] = '{13'h0000, 13'h0200, 13'h0100, 13'h0400};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // Register reset values, masks, unmapped places
      for (int i = 0; i < 2; i++) begin
         bus(1'b0, 32'(i * 4), 32'h0);
         chk("reg_reset", rd, 32'h0);
      end
      bus(1'b1, 32'h0, 32'hffffffff);
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl_mask", rd, 32'h7);
      bus(1'b1, 32'h10, 32'hffffffff);
      bus(1'b0, 32'h10, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b0, 32'h100, 32'h0);
      chk("high_addr", rd, 32'h0);
      // Corner and random steady patterns
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         s = (i < 4) ? cor[i] : rnd[12:0] & 13'h1b1f;
         put(s);
         chk("lamps", 32'(lamps), 32'(exp_lamps(s)));
      end
      bus(1'b1, 32'h8, 32'h0);
      bus(1'b0, 32'h8, 32'h0);
      chk("lamp_reg", rd, 32'(exp_lamps(s)));
      // Flash rates seen by the operator
      for (int k = 0; k < 4; k++) begin
         put(fst[k]);
         @(posedge hclk);
         clr <= 1'b1;
         @(posedge hclk);
         clr <= 1'b0;
         tick(80);
         chk("flash_half", 32'(lit_len[fidx[k]]), (k == 0) ? 4 * HALF : HALF);
      end
      // Selected group with group six when the link is missing
      for (int sel = 0; sel < 6; sel++) begin
         bus(1'b1, 32'h0, 32'(sel));
         put(13'h0080);
         chk("groups", 32'(grp), (sel == 0) ? 32'h20 : 32'h20 | (32'h1 << (sel - 1)));
      end
      put(13'h0401);
      chk("safety_fault", 32'(lamps[3:0]), 32'h1);
      // Forced states under update, then display modes
      put(13'h0200);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         s = rnd[12:0] & 13'h07ff;
         bus(1'b1, 32'h4, 32'(s));
         bus(1'b0, 32'h4, 32'h0);
         chk("state_reg", rd, 32'(s));
         bus(1'b0, 32'hc, 32'h0);
         chk("effective", 32'(rd[20:8]), 32'(s | 13'h0200));
      end
      bus(1'b1, 32'h4, 32'h0);
      for (int i = 0; i < 4; i++) begin
         put(mst[i]);
         bus(1'b0, 32'hc, 32'h0);
         chk("mode", 32'(rd[1:0]), 32'(i));
      end
      // Clock enable low freezes the lamps
      put(13'h0010);
      @(posedge hclk);
      ce <= 1'b0;
      state_in <= 13'h0001;
      tick(3);
      chk("freeze", 32'(lamps), 32'(exp_lamps(13'h0010)));
      @(posedge hclk);
      ce <= 1'b1;
      tick(2);
      chk("thaw", 32'(lamps), 32'(exp_lamps(13'h0001)));
      // Reset in mid-run
      @(posedge hclk);
      hresetn <= 1'b0;
      tick(1);
      chk("reset_lamps", 32'(lamps), 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      tick(2);
      chk("after_reset", 32'(lamps), 32'(exp_lamps(13'h0001)));
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl_after_reset", rd, 32'h0);
      complete_run();
   end
endmodule : testbench
